//--- hdl/msc_stat_counters.v
// MAC statistics counter bank: receive lengths, rx LPI, transmit errors
//
// Implementation choices: the register addresses and the address-and-strobe port.
`include "msc_map.vh"
`default_nettype none
// Widths default to the sizes software expects to read
module msc_stat_counters #(
  parameter LEN_W = 14,
  parameter CNT_W = 20,
  parameter WIDE_W = 32,
  parameter COLL_W = 5
) (
  input wire clk_sys,
  input wire rst_b,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_q,
  output reg irq_q,
  // Receive status, one pulse per finished frame
  input wire rx_done,
  input wire [LEN_W-1:0] rx_len,
  input wire rx_good,
  input wire rx_filter_pass,
  input wire rx_fifo_ovf,
  // PHY receive low-power-idle indication, asynchronous pin
  input wire phy_rx_lpi,
  // Transmit status, one pulse per finished attempt
  input wire tx_done,
  input wire tx_ok,
  input wire tx_fcs_bad,
  input wire tx_carrier_err,
  input wire [15:0] tx_len,
  input wire [COLL_W-1:0] tx_collisions,
  // Transmit deferral: level while deferring, pulse per byte time
  input wire tx_deferring,
  input wire tx_byte_tick,
  // Controls to the transmitter and receive engine
  output reg energy_efficient_enable_q,
  output reg force_bad_checksum_q,
  output reg [LEN_W-1:0] max_frame_size_q
);
  // Prescaler sized for one microsecond of clock cycles; a faster
  // clock needs a new last count, and a wider prescaler past 256 cycles
  localparam PRE_W = 8;
  localparam [PRE_W-1:0] US_LAST = `MSC_US_LAST;

  // Register state
  reg [`MSC_INT_W-1:0] int_sts_q;
  reg [`MSC_INT_W-1:0] int_sts_d;
  reg [`MSC_INT_W-1:0] int_mask_q;
  reg [`MSC_INT_W-1:0] int_mask_d;
  reg [31:0] rdata_d;

  // Synchronised LPI level and its last value
  wire lpi_s;
  reg lpi_prev_q;
  reg [PRE_W-1:0] us_pre_q;

  // Deferral timer in byte times
  reg [15:0] defer_tmr_q;
  reg defer_hit_q;
  wire [15:0] defer_limit;
  wire defer_cross;

  // Counter values
  wire [CNT_W-1:0] c_rx512;
  wire [CNT_W-1:0] c_rx1024;
  wire [CNT_W-1:0] c_rxbig;
  wire [WIDE_W-1:0] c_lpi_ent;
  wire [WIDE_W-1:0] c_lpi_time;
  wire [CNT_W-1:0] c_txfcs;
  wire [CNT_W-1:0] c_defer;
  wire [CNT_W-1:0] c_carr;
  wire [WIDE_W-1:0] c_badb;
  wire [CNT_W-1:0] c_scol;
  wire [CNT_W-1:0] c_mcol;

  // Count conditions
  wire rx_cnt_ok;
  wire inc_rx512;
  wire inc_rx1024;
  wire inc_rxbig;
  wire lpi_rise;
  wire us_tick;
  wire lpi_clr;
  wire tx_fcs_err;
  wire tx_failed;
  wire inc_scol;
  wire inc_mcol;
  wire [`MSC_INT_W-1:0] int_evt;

  // Pin input through two flops before use
  msc_sync u_lpi_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .d_in(phy_rx_lpi),
    .d_out_q(lpi_s)
  );

  // Only frames that passed filtering and reached the FIFO count
  // Length bounds are inclusive at both ends
  assign rx_cnt_ok = rx_done & rx_good & rx_filter_pass & ~rx_fifo_ovf;
  assign inc_rx512 = rx_cnt_ok & (rx_len >= `MSC_LEN_512) &
                     (rx_len <= `MSC_LEN_1023);
  assign inc_rx1024 = rx_cnt_ok & (rx_len >= `MSC_LEN_1024) &
                      (rx_len <= `MSC_LEN_1518);
  assign inc_rxbig = rx_cnt_ok & (rx_len > `MSC_LEN_1518);

  // LPI edge and timing; no power-state gating so suspend keeps counting
  assign lpi_clr = ~energy_efficient_enable_q;
  assign lpi_rise = lpi_s & ~lpi_prev_q & ~lpi_clr;
  assign us_tick = lpi_s & (us_pre_q == US_LAST);

  // Forced corruption always ends as an FCS error on the wire
  assign tx_fcs_err = tx_done & (tx_fcs_bad | force_bad_checksum_q);
  assign tx_failed = tx_done & ~tx_ok;
  // Collision counts only for frames that finally went out
  assign inc_scol = tx_done & tx_ok &
                    (tx_collisions == {{(COLL_W-1){1'b0}}, 1'b1});
  assign inc_mcol = tx_done & tx_ok &
                    (tx_collisions > {{(COLL_W-1){1'b0}}, 1'b1});

  // Limit is two maximum frames plus margin, in byte times
  assign defer_limit = {1'b0, max_frame_size_q, 1'b0} +
                       `MSC_DEFER_MARGIN;
  assign defer_cross = tx_deferring & tx_byte_tick & ~defer_hit_q &
                       (defer_tmr_q >= defer_limit);

  // Interrupt events
  // Bit order matches the status layout, highest first
  assign int_evt = {defer_cross, tx_failed, lpi_rise, rx_cnt_ok};

  // Previous LPI level and microsecond prescaler
  // Clear while disabled, so the first rise after enable counts once
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lpi_prev_q <= 1'b0;
      us_pre_q <= {PRE_W{1'b0}};
    end else if (lpi_clr) begin
      // Held idle so a fresh enable starts from zero
      lpi_prev_q <= 1'b0;
      us_pre_q <= {PRE_W{1'b0}};
    end else begin
      lpi_prev_q <= lpi_s;
      // Fraction kept across gaps so no time is lost
      if (lpi_s) begin
        if (us_pre_q == US_LAST) begin
          us_pre_q <= {PRE_W{1'b0}};
        end else begin
          us_pre_q <= us_pre_q + 8'h01;
        end
      end
    end
  end

  // Deferral timer, restarted whenever deferral drops
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      defer_tmr_q <= 16'h0000;
      defer_hit_q <= 1'b0;
    end else if (!tx_deferring) begin
      // Collision and back-off end the deferral; start over
      defer_tmr_q <= 16'h0000;
      defer_hit_q <= 1'b0;
    end else begin
      // Saturate rather than wrap, so a stuck deferral cannot recount
      if (tx_byte_tick && defer_tmr_q != 16'hFFFF) begin
        defer_tmr_q <= defer_tmr_q + 16'h0001;
      end
      // One count per deferral, however long it lasts
      if (defer_cross) begin
        defer_hit_q <= 1'b1;
      end
    end
  end

  // Receive length counters
  // These never clear; software works with differences
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_rx512 (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(inc_rx512), .step(1'b1), .count_q(c_rx512)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_rx1024 (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(inc_rx1024), .step(1'b1), .count_q(c_rx1024)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_rxbig (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(inc_rxbig), .step(1'b1), .count_q(c_rxbig)
  );

  // Receive LPI counters, held clear while disabled
  msc_counter #(.WIDTH(WIDE_W), .STEP_W(1)) u_lpi_ent (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(lpi_clr),
    .inc(lpi_rise), .step(1'b1), .count_q(c_lpi_ent)
  );
  msc_counter #(.WIDTH(WIDE_W), .STEP_W(1)) u_lpi_time (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(lpi_clr),
    .inc(us_tick), .step(1'b1), .count_q(c_lpi_time)
  );

  // Transmit error counters
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_txfcs (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(tx_fcs_err), .step(1'b1), .count_q(c_txfcs)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_defer (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(defer_cross), .step(1'b1), .count_q(c_defer)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_carr (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(tx_done & tx_carrier_err), .step(1'b1), .count_q(c_carr)
  );
  msc_counter #(.WIDTH(WIDE_W), .STEP_W(16)) u_badb (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(tx_failed), .step(tx_len), .count_q(c_badb)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_scol (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(inc_scol), .step(1'b1), .count_q(c_scol)
  );
  msc_counter #(.WIDTH(CNT_W), .STEP_W(1)) u_mcol (
    .clk_sys(clk_sys), .rst_b(rst_b), .clr(1'b0),
    .inc(inc_mcol), .step(1'b1), .count_q(c_mcol)
  );

  // Control register writes
  // Writes to counter and status offsets are dropped without error
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      energy_efficient_enable_q <= 1'b0;
      force_bad_checksum_q <= 1'b0;
      max_frame_size_q <= `MSC_MAXSIZE_RST;
      int_mask_q <= `MSC_MASK_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        `MSC_OFS_CTRL: begin
          energy_efficient_enable_q <= reg_wdata[`MSC_CTRL_EEE_BIT];
          force_bad_checksum_q <= reg_wdata[`MSC_CTRL_FORCE_BIT];
        end
        `MSC_OFS_RXCFG: begin
          max_frame_size_q <= reg_wdata[LEN_W-1:0];
        end
        `MSC_OFS_INT_MASK: begin
          int_mask_q <= reg_wdata[`MSC_INT_W-1:0];
        end
        default: begin
          // Counters and status ignore writes
        end
      endcase
    end
  end

  // Sticky status: a read clears, a new event in that cycle still sets
  always @* begin
    int_sts_d = int_sts_q;
    if (reg_rd && reg_addr == `MSC_OFS_INT_STS) begin
      int_sts_d = {`MSC_INT_W{1'b0}};
    end
    int_sts_d = int_sts_d | int_evt;
  end

  // Next mask, so the interrupt follows a mask write without a lag
  always @* begin
    int_mask_d = int_mask_q;
    if (reg_wr && reg_addr == `MSC_OFS_INT_MASK) begin
      int_mask_d = reg_wdata[`MSC_INT_W-1:0];
    end
  end

  // Status and interrupt output
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      int_sts_q <= {`MSC_INT_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      int_sts_q <= int_sts_d;
      // Built from next status and mask, so it matches them each cycle
      irq_q <= |(int_sts_d & int_mask_d);
    end
  end

  // Read mux; unmapped offsets read zero
  // Counters are read live; a wide value may move between two reads
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `MSC_OFS_CTRL: begin
        rdata_d[`MSC_CTRL_EEE_BIT] = energy_efficient_enable_q;
        rdata_d[`MSC_CTRL_FORCE_BIT] = force_bad_checksum_q;
      end
      `MSC_OFS_RXCFG: rdata_d[LEN_W-1:0] = max_frame_size_q;
      `MSC_OFS_INT_STS: rdata_d[`MSC_INT_W-1:0] = int_sts_q;
      `MSC_OFS_INT_MASK: rdata_d[`MSC_INT_W-1:0] = int_mask_q;
      `MSC_OFS_RX_512: rdata_d[CNT_W-1:0] = c_rx512;
      `MSC_OFS_RX_1024: rdata_d[CNT_W-1:0] = c_rx1024;
      `MSC_OFS_RX_BIG: rdata_d[CNT_W-1:0] = c_rxbig;
      `MSC_OFS_LPI_ENTRY: rdata_d = c_lpi_ent;
      `MSC_OFS_LPI_TIME: rdata_d = c_lpi_time;
      `MSC_OFS_TX_FCS: rdata_d[CNT_W-1:0] = c_txfcs;
      `MSC_OFS_TX_DEFER: rdata_d[CNT_W-1:0] = c_defer;
      `MSC_OFS_TX_CARR: rdata_d[CNT_W-1:0] = c_carr;
      `MSC_OFS_TX_BADB: rdata_d = c_badb;
      `MSC_OFS_TX_SCOL: rdata_d[CNT_W-1:0] = c_scol;
      `MSC_OFS_TX_MCOL: rdata_d[CNT_W-1:0] = c_mcol;
      default: rdata_d = 32'h00000000;
    endcase
  end

  // Read data registered, valid the cycle after the strobe only
  // Zero between reads keeps stale values off the bus
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end
endmodule // msc_stat_counters
`default_nettype wire

//--- hdl/msc_map.vh
// Register map, field layout, reset values and timing for the counter bank
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

// Register byte offsets
`define MSC_OFS_CTRL      8'h00
`define MSC_OFS_RXCFG     8'h04
`define MSC_OFS_INT_STS   8'h08
`define MSC_OFS_INT_MASK  8'h0C
`define MSC_OFS_RX_512    8'h10
`define MSC_OFS_RX_1024   8'h14
`define MSC_OFS_RX_BIG    8'h18
`define MSC_OFS_LPI_ENTRY 8'h1C
`define MSC_OFS_LPI_TIME  8'h20
`define MSC_OFS_TX_FCS    8'h24
`define MSC_OFS_TX_DEFER  8'h28
`define MSC_OFS_TX_CARR   8'h2C
`define MSC_OFS_TX_BADB   8'h30
`define MSC_OFS_TX_SCOL   8'h34
`define MSC_OFS_TX_MCOL   8'h38

// Control register fields
`define MSC_CTRL_EEE_BIT  0
`define MSC_CTRL_FORCE_BIT 1

// Interrupt status and mask layout
`define MSC_INT_W         4
`define MSC_INT_RX_FRAME  0
`define MSC_INT_LPI_ENTRY 1
`define MSC_INT_TX_ERROR  2
`define MSC_INT_DEFER     3

// Reset values
`define MSC_CTRL_RST      2'h0
`define MSC_MAXSIZE_RST   14'h05EE
`define MSC_MASK_RST      4'h0

// Frame length bounds in bytes
`define MSC_LEN_512       14'h0200
`define MSC_LEN_1023      14'h03FF
`define MSC_LEN_1024      14'h0400
`define MSC_LEN_1518      14'h05EE

// Deferral margin in bytes
`define MSC_DEFER_MARGIN  16'h0010

// Timing: last prescaler count of one microsecond, 25 cycles of 40 ns
`define MSC_US_LAST       8'h18

`endif

//--- hdl/msc_sync.v
// Two-stage synchroniser for a level from outside the clock domain
`default_nettype none
module msc_sync (
  input wire clk_sys,
  input wire rst_b,
  input wire d_in,
  output reg d_out_q
);
  // First stage, read only by the second
  reg meta_q;

  // Two flops in series to settle metastability
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= 1'b0;
      d_out_q <= 1'b0;
    end else begin
      meta_q <= d_in;
      d_out_q <= meta_q;
    end
  end
endmodule // msc_sync
`default_nettype wire

//--- hdl/msc_counter.v
// Wrapping statistics counter with synchronous clear and variable step
`default_nettype none
module msc_counter #(
  parameter WIDTH = 20,
  parameter STEP_W = 1
) (
  input wire clk_sys,
  input wire rst_b,
  input wire clr,
  input wire inc,
  input wire [STEP_W-1:0] step,
  output reg [WIDTH-1:0] count_q
);
  // Step widened or cut to the counter width
  wire [WIDTH+STEP_W-1:0] step_ext;
  wire [WIDTH-1:0] count_d;

  assign step_ext = {{WIDTH{1'b0}}, step};
  // Sum wraps naturally at full scale
  assign count_d = count_q + step_ext[WIDTH-1:0];

  // Clear has priority over increment
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= {WIDTH{1'b0}};
    end else if (clr) begin
      count_q <= {WIDTH{1'b0}};
    end else if (inc) begin
      count_q <= count_d;
    end
  end
endmodule // msc_counter
`default_nettype wire

//--- tb/msc_phy_model.sv
// Behavioural PHY model driving the receive low-power-idle pin
`default_nettype none
module msc_phy_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [7:0] hold_cycles,
  output var logic phy_rx_lpi
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q; // Idle cycles still to show
  // Raise the idle level for a span, then drop it to active
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 8'h00;
      phy_rx_lpi <= 1'b0;
    end else if (start) begin
      left_q <= hold_cycles - 8'h01;
      phy_rx_lpi <= 1'b1;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end else begin
      phy_rx_lpi <= 1'b0; // Span over, link active again
    end
  end
endmodule // msc_phy_model
`default_nettype wire

//--- tb/msc_stat_props.sv
// Assertion checker for the counter bank register side
`include "msc_map.vh"
`default_nettype none
module msc_stat_props #(
  parameter LEN_W = 14
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata_q,
  input wire logic energy_efficient_enable_q,
  input wire logic force_bad_checksum_q,
  input wire logic [LEN_W-1:0] max_frame_size_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ctrl_wr; // Write aimed at the control register
  logic cfg_wr; // Write aimed at the size register
  logic narrow_rd; // Read of a 20-bit counter
  logic lpi_rd; // Read of an idle counter
  assign ctrl_wr = reg_wr && reg_addr == `MSC_OFS_CTRL;
  assign cfg_wr = reg_wr && reg_addr == `MSC_OFS_RXCFG;
  assign narrow_rd = reg_rd && reg_addr inside {8'h10, 8'h14, 8'h18,
    8'h24, 8'h28, 8'h2C, 8'h34, 8'h38};
  assign lpi_rd = reg_rd && reg_addr inside {8'h1C, 8'h20};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_eee_write: assert property (ctrl_wr |=>
    energy_efficient_enable_q == $past(reg_wdata[0]))
    else $error("enable bit not taken from write");
  a_force_write: assert property (ctrl_wr |=>
    force_bad_checksum_q == $past(reg_wdata[1]))
    else $error("bad checksum bit not taken from write");
  a_size_write: assert property (cfg_wr |=>
    max_frame_size_q == $past(reg_wdata[LEN_W-1:0]))
    else $error("max size not taken from write");
  a_ctrl_hold: assert property (!ctrl_wr |=>
    $stable({energy_efficient_enable_q, force_bad_checksum_q}))
    else $error("control bits moved without write");
  a_size_hold: assert property (!cfg_wr |=> $stable(max_frame_size_q))
    else $error("max size moved without write");
  a_narrow_width: assert property (narrow_rd |=>
    reg_rdata_q[31:20] == 12'h000)
    else $error("upper bits of narrow counter set");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata_q == 32'h0000_0000)
    else $error("read data outside read cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 8'h38 |=>
    reg_rdata_q == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_lpi_clear: assert property (lpi_rd && !energy_efficient_enable_q &&
    !$past(energy_efficient_enable_q) && !$past(energy_efficient_enable_q, 2)
    |=> reg_rdata_q == 32'h0000_0000)
    else $error("idle counter not held clear");
  c_ctrl_wr: cover property (ctrl_wr);
  c_lpi_rd: cover property (lpi_rd ##1 reg_rdata_q != 32'h0000_0000);
  c_narrow_rd: cover property (narrow_rd ##1 reg_rdata_q != 32'h0000_0000);
endmodule // msc_stat_props
bind msc_stat_counters msc_stat_props #(.LEN_W(LEN_W)) u_props (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata_q(reg_rdata_q),
  .energy_efficient_enable_q(energy_efficient_enable_q),
  .force_bad_checksum_q(force_bad_checksum_q),
  .max_frame_size_q(max_frame_size_q));
`default_nettype wire

//--- tb/tb_msc_stat_counters.sv
// Self-checking bench for the statistics counter bank
`include "msc_map.vh"
`default_nettype none
module tb_msc_stat_counters;
  timeunit 1ns;
  timeprecision 1ps;
  // One received frame and the bucket it should land in, 3 for none
  typedef struct {
    logic [13:0] len;
    logic good, filt, ovf;
    int bkt;
  } msc_row_t;
  msc_row_t rows [10] = '{
    '{14'h01FF, 1'h1, 1'h1, 1'h0, 3},
    '{14'h0200, 1'h1, 1'h1, 1'h0, 0},
    '{14'h03FF, 1'h1, 1'h1, 1'h0, 0},
    '{14'h0400, 1'h1, 1'h1, 1'h0, 1},
    '{14'h05EE, 1'h1, 1'h1, 1'h0, 1},
    '{14'h05EF, 1'h1, 1'h1, 1'h0, 2},
    '{14'h3FFF, 1'h1, 1'h1, 1'h0, 2},
    '{14'h0258, 1'h0, 1'h1, 1'h0, 3},
    '{14'h0258, 1'h1, 1'h0, 1'h0, 3},
    '{14'h0500, 1'h1, 1'h1, 1'h1, 3}};
  logic clk_sys = 1'b0, rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata_q;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq_q, ee, force_bad;
  logic rx_done = 1'b0, rx_good = 1'b0, rx_filter_pass = 1'b0;
  logic rx_fifo_ovf = 1'b0, phy_rx_lpi, lpi_start = 1'b0;
  logic [13:0] rx_len = 14'h0, max_size;
  logic tx_done = 1'b0, tx_ok = 1'b0, tx_fcs_bad = 1'b0;
  logic tx_carrier_err = 1'b0, tx_deferring = 1'b0, tx_byte_tick = 1'b0;
  logic [15:0] tx_len = 16'h0;
  logic [4:0] tx_collisions = 5'h00;
  logic [7:0] lpi_hold = 8'h00;
  int err_count = 0, compares = 0, cnt [4] = '{0, 0, 0, 0};
  always #20 clk_sys = ~clk_sys; // 25 MHz
  msc_stat_counters u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
    .rx_done(rx_done), .rx_len(rx_len), .rx_good(rx_good),
    .rx_filter_pass(rx_filter_pass), .rx_fifo_ovf(rx_fifo_ovf),
    .phy_rx_lpi(phy_rx_lpi), .tx_done(tx_done), .tx_ok(tx_ok),
    .tx_fcs_bad(tx_fcs_bad), .tx_carrier_err(tx_carrier_err),
    .tx_len(tx_len), .tx_collisions(tx_collisions),
    .tx_deferring(tx_deferring), .tx_byte_tick(tx_byte_tick),
    .energy_efficient_enable_q(ee), .force_bad_checksum_q(force_bad),
    .max_frame_size_q(max_size));
  msc_phy_model u_phy (.clk_sys(clk_sys), .rst_b(rst_b),
    .start(lpi_start), .hold_cycles(lpi_hold), .phy_rx_lpi(phy_rx_lpi));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic rd(input string nm, input logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(nm, reg_rdata_q, e);
  endtask
  task automatic rx_frame(input msc_row_t r);
    @(posedge clk_sys);
    {rx_done, rx_len, rx_good} <= {1'b1, r.len, r.good};
    {rx_filter_pass, rx_fifo_ovf} <= {r.filt, r.ovf};
    @(posedge clk_sys);
    rx_done <= 1'b0;
  endtask
  task automatic tx(input logic ok, fcs, car, [15:0] n, [4:0] col);
    @(posedge clk_sys);
    {tx_done, tx_ok, tx_fcs_bad, tx_carrier_err} <= {1'b1, ok, fcs, car};
    {tx_len, tx_collisions} <= {n, col};
    @(posedge clk_sys);
    tx_done <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      tx_byte_tick <= 1'b1;
      @(posedge clk_sys);
      tx_byte_tick <= 1'b0;
    end
  endtask
  // Restart deferral: one low cycle clears the timer
  task automatic defer_restart;
    @(posedge clk_sys);
    tx_deferring <= 1'b0;
    @(posedge clk_sys);
    tx_deferring <= 1'b1;
  endtask
  task automatic lpi_go(input logic [7:0] h, input int gap);
    @(posedge clk_sys);
    {lpi_start, lpi_hold} <= {1'b1, h};
    @(posedge clk_sys);
    lpi_start <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd("ctrl", `MSC_OFS_CTRL, 32'h0);
    rd("size", `MSC_OFS_RXCFG, 32'h5EE);
    rd("unmapped", 8'h40, 32'h0);
    for (int i = 0; i < 11; i++) rd("zero", 8'h10 + 8'(4 * i), 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      rx_frame(rows[i]);
      cnt[rows[i].bkt]++;
      rd("rx512", `MSC_OFS_RX_512, cnt[0]);
      rd("rx1024", `MSC_OFS_RX_1024, cnt[1]);
      rd("rxbig", `MSC_OFS_RX_BIG, cnt[2]);
    end
    $display("test rx lengths done");
    tx(1'b0, 1'b1, 1'b1, 16'h0064, 5'h00);
    tx(1'b0, 1'b0, 1'b0, 16'h05DC, 5'h03);
    tx(1'b1, 1'b0, 1'b0, 16'h0040, 5'h01);
    tx(1'b1, 1'b0, 1'b0, 16'h0040, 5'h02);
    tx(1'b1, 1'b0, 1'b0, 16'h0040, 5'h10);
    wr(`MSC_OFS_CTRL, 32'h2);
    #1 chk("force", force_bad, 32'h1);
    tx(1'b1, 1'b0, 1'b0, 16'h0040, 5'h00);
    wr(`MSC_OFS_CTRL, 32'h0);
    rd("fcs", `MSC_OFS_TX_FCS, 32'h2);
    rd("carrier", `MSC_OFS_TX_CARR, 32'h1);
    rd("badbytes", `MSC_OFS_TX_BADB, 32'h640);
    rd("single", `MSC_OFS_TX_SCOL, 32'h1);
    rd("multi", `MSC_OFS_TX_MCOL, 32'h2);
    $display("test tx errors done");
    wr(`MSC_OFS_RXCFG, 32'h1);
    defer_restart();
    tick(10);
    defer_restart();
    tick(10);
    rd("defer", `MSC_OFS_TX_DEFER, 32'h0);
    defer_restart();
    tick(18);
    rd("defer", `MSC_OFS_TX_DEFER, 32'h0);
    tick(1);
    rd("defer", `MSC_OFS_TX_DEFER, 32'h1);
    tick(3);
    rd("defer", `MSC_OFS_TX_DEFER, 32'h1);
    @(posedge clk_sys);
    tx_deferring <= 1'b0;
    $display("test deferral done");
    wr(`MSC_OFS_CTRL, 32'h1);
    lpi_go(8'd60, 80);
    lpi_go(8'd15, 30);
    rd("lpi_entry", `MSC_OFS_LPI_ENTRY, 32'h2);
    rd("lpi_time", `MSC_OFS_LPI_TIME, 32'h3);
    wr(`MSC_OFS_CTRL, 32'h0);
    rd("lpi_entry", `MSC_OFS_LPI_ENTRY, 32'h0);
    rd("lpi_time", `MSC_OFS_LPI_TIME, 32'h0);
    lpi_go(8'd40, 50);
    rd("lpi_entry", `MSC_OFS_LPI_ENTRY, 32'h0);
    rd("lpi_time", `MSC_OFS_LPI_TIME, 32'h0);
    $display("test idle counters done");
    rd("sts", `MSC_OFS_INT_STS, 32'hF);
    wr(`MSC_OFS_INT_MASK, 32'h1);
    rx_frame(rows[1]);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq", irq_q, 32'h1);
    rd("sts", `MSC_OFS_INT_STS, 32'h1);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", irq_q, 32'h0);
    wr(`MSC_OFS_INT_MASK, 32'h0);
    rx_frame(rows[1]);
    repeat (3) @(posedge clk_sys);
    #1 chk("irq", irq_q, 32'h0);
    rd("sts", `MSC_OFS_INT_STS, 32'h1);
    $display("test interrupt done");
    stop_test();
  end
endmodule // tb_msc_stat_counters
`default_nettype wire
